// ==== design/mss_pkg.sv ====
/*
 * Shared constants of the multi-rail reset supervisor: register offsets,
 * field positions, reset values, timing figures and the sequencer states.
 * Assumes a single 200 MHz clock drives every consumer of these values.
 */
`default_nettype none
package mss_pkg;

    // Clock and time base
    localparam int unsigned CLOCK_PERIOD_PS = 5000;
    localparam int unsigned TICK_NS         = 1000;
    localparam int unsigned TICK_CYCLES     = (TICK_NS * 1000) / CLOCK_PERIOD_PS;

    // Reset timeout choices, in milliseconds, and the watchdog period
    localparam int unsigned TIMEOUT_0_MS    = 50;
    localparam int unsigned TIMEOUT_1_MS    = 100;
    localparam int unsigned TIMEOUT_2_MS    = 200;
    localparam int unsigned TIMEOUT_3_MS    = 400;
    localparam int unsigned WATCHDOG_MS     = 1600;
    localparam int unsigned TICKS_PER_MS    = 1000000 / TICK_NS;
    localparam int unsigned WATCHDOG_TICKS  = WATCHDOG_MS * TICKS_PER_MS;

    // Glitch filter on each rail indication
    localparam int unsigned GLITCH_NS       = 10000;
    localparam int unsigned GLITCH_CYCLES   =
        (GLITCH_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

    // Comparator reference of the adjustable inputs and power-fail input
    localparam int unsigned ADJ_REF_MV      = 500;

    localparam int unsigned RAILS           = 4;
    localparam int unsigned CNT_W           = 24;
    localparam int unsigned FLT_W           = 12;

    // Register map (byte addresses)
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h08;
    localparam logic [7:0]  OFS_STATE       = 8'h0c;

    // Control fields
    localparam int unsigned CTRL_FORCE_BIT  = 0;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

    // Interrupt fields
    localparam int unsigned IRQ_W           = 4;
    localparam int unsigned IRQ_RESET_BIT   = 0;
    localparam int unsigned IRQ_WDOG_BIT    = 1;
    localparam int unsigned IRQ_PFAIL_BIT   = 2;
    localparam int unsigned IRQ_UV_BIT      = 3;
    localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;

    // State register fields
    localparam int unsigned ST_RAILS_LSB    = 0;
    localparam int unsigned ST_RESET_BIT    = 4;
    localparam int unsigned ST_WDOG_BIT     = 5;
    localparam int unsigned ST_PFAIL_BIT    = 6;
    localparam int unsigned ST_MANUAL_BIT   = 7;
    localparam int unsigned ST_FSM_LSB      = 8;

    typedef enum logic [2:0] {
        MSS_HOLD  = 3'b001,
        MSS_DELAY = 3'b010,
        MSS_RUN   = 3'b100
    } mss_state_e;

    // Reset timeout length in ticks for a given build-time selection
    function automatic int unsigned mss_timeout_ticks(input int unsigned sel);
        case (sel)
            0:       return TIMEOUT_0_MS * TICKS_PER_MS;
            1:       return TIMEOUT_1_MS * TICKS_PER_MS;
            2:       return TIMEOUT_2_MS * TICKS_PER_MS;
            default: return TIMEOUT_3_MS * TICKS_PER_MS;
        endcase
    endfunction

endpackage
`default_nettype wire

// ==== design/mss_supervisor.sv ====
/*
 * Multi-rail reset supervisor: filtered under-voltage indications from up
 * to four rails, manual reset, software force, watchdog with optional
 * dedicated output, power-fail flag, and a small register port with a
 * sticky interrupt.
 * Assumes every input is synchronous to clock; comparators outside deliver
 * a high level while a rail or the power-fail input is below threshold.
 */
`timescale 1ns/1ps
`default_nettype none

module mss_supervisor
    import mss_pkg::*;
#(
    parameter int unsigned TIMEOUT_SEL     = 2,
    parameter int unsigned RESET_TICKS     = mss_timeout_ticks(TIMEOUT_SEL),
    parameter int unsigned WDOG_TICKS      = WATCHDOG_TICKS,
    parameter logic [3:0]  RAIL_ENABLE     = 4'hf,
    parameter bit          HAS_MANUAL      = 1'b1,
    parameter bit          HAS_WDOG_OUT    = 1'b0,
    parameter bit          HAS_PFAIL       = 1'b0,
    parameter bit          RESET_HIGH      = 1'b0,
    parameter bit          RESET_OPEN      = 1'b1,
    parameter bit          WDOG_OPEN       = 1'b1
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        primary_supply_monitor,
    input  wire logic        secondary_supply_monitor,
    input  wire logic        adjustable_monitor_a,
    input  wire logic        adjustable_monitor_b,
    input  wire logic        manual_reset_n,
    input  wire logic        watchdog_kick_in,
    input  wire logic        watchdog_kick_open,
    input  wire logic        power_fail_sense,
    output logic             reset_out_low,
    output logic             reset_out_low_oe,
    output logic             watchdog_expired_n,
    output logic             watchdog_expired_n_oe,
    output logic             power_fail_warn_n,
    output logic             power_fail_warn_n_oe,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    output logic             irq
);

    logic [RAILS-1:0]   rail_raw;
    logic [RAILS-1:0]   rail_low;
    mss_state_e         state;
    logic [CNT_W-1:0]   delay_cnt;
    logic [CNT_W-1:0]   wdog_cnt;
    logic [7:0]         tick_cnt;
    logic               tick;
    logic               kick_q;
    logic               kick_edge;
    logic               wdog_enable;
    logic               wdog_over;
    logic               wdog_flag;
    logic               uv_cause;
    logic               manual_on;
    logic               hold_cause;
    logic               reset_active;
    logic [31:0]        ctrl;
    logic [IRQ_W-1:0]   irq_status;
    logic [IRQ_W-1:0]   irq_mask;
    logic [IRQ_W-1:0]   irq_event;
    logic [IRQ_W-1:0]   irq_clear;
    logic               pfail_q;
    logic               rail_any_q;

    // Adjustable rails compare outside against the 0.5 V reference and
    // enter the same filter and reset path as the fixed rails
    assign rail_raw = {adjustable_monitor_b, adjustable_monitor_a,
                       secondary_supply_monitor, primary_supply_monitor}
                      & RAIL_ENABLE;

    // Glitch filter: a rail counts as low only after a steady low
    // indication, and as good again only after a steady good one
    for (genvar g = 0; g < RAILS; g++) begin : g_filter
        logic [FLT_W-1:0] flt_cnt;
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                flt_cnt     <= '0;
                rail_low[g] <= 1'b0;
            end else if (rail_raw[g] == rail_low[g]) begin
                flt_cnt <= '0;
            end else if (flt_cnt == FLT_W'(GLITCH_CYCLES - 1)) begin
                flt_cnt     <= '0;
                rail_low[g] <= rail_raw[g];
            end else begin
                flt_cnt <= flt_cnt + 1'b1;
            end
        end
    end

    // Microsecond tick; long counts run on it to keep counters narrow
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
        end else if (tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end
    assign tick = (tick_cnt == 8'(TICK_CYCLES - 1));

    // No debounce here: a bouncing button restarts the timeout each bounce
    assign manual_on  = HAS_MANUAL && !manual_reset_n;
    assign hold_cause = (|rail_low) || manual_on
                        || ctrl[CTRL_FORCE_BIT]
                        || (wdog_over && !HAS_WDOG_OUT);

    // Reset sequencer; power up enters the timeout directly
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state     <= MSS_DELAY;
            delay_cnt <= '0;
        end else begin
            case (state)
                MSS_HOLD: begin
                    delay_cnt <= '0;
                    if (!hold_cause) begin
                        state <= MSS_DELAY;
                    end
                end
                MSS_DELAY: begin
                    if (hold_cause) begin
                        state     <= MSS_HOLD;
                        delay_cnt <= '0;
                    end else if (tick) begin
                        if (delay_cnt == CNT_W'(RESET_TICKS - 1)) begin
                            state     <= MSS_RUN;
                            delay_cnt <= '0;
                        end else begin
                            delay_cnt <= delay_cnt + 1'b1;
                        end
                    end
                end
                MSS_RUN: begin
                    delay_cnt <= '0;
                    if (hold_cause) begin
                        state <= MSS_HOLD;
                    end
                end
                default: begin
                    state     <= MSS_HOLD;
                    delay_cnt <= '0;
                end
            endcase
        end
    end
    assign reset_active = (state != MSS_RUN);

    // Remember that the present reset came from an under-voltage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            uv_cause <= 1'b0;
        end else if (|rail_low) begin
            uv_cause <= 1'b1;
        end else if (!reset_active) begin
            uv_cause <= 1'b0;
        end
    end

    // Watchdog; a floating kick input only disables it without own output
    assign kick_edge   = (watchdog_kick_in != kick_q);
    assign wdog_enable = HAS_WDOG_OUT || !watchdog_kick_open;
    assign wdog_over   = wdog_enable && !reset_active && tick
                         && (wdog_cnt == CNT_W'(WDOG_TICKS - 1));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            kick_q <= 1'b0;
        end else begin
            kick_q <= watchdog_kick_in;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wdog_cnt <= '0;
        end else if (reset_active || kick_edge || !wdog_enable) begin
            wdog_cnt <= '0;
        end else if (wdog_over) begin
            wdog_cnt <= '0;
        end else if (tick) begin
            wdog_cnt <= wdog_cnt + 1'b1;
        end
    end

    // Dedicated output stays asserted until the next kick or a reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wdog_flag <= 1'b0;
        end else if (wdog_over && HAS_WDOG_OUT) begin
            wdog_flag <= 1'b1;
        end else if (kick_edge || reset_active) begin
            wdog_flag <= 1'b0;
        end
    end

    // Pin drivers; open drain pulls low only, so its level is constant
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reset_out_low         <= RESET_HIGH && !RESET_OPEN;
            reset_out_low_oe      <= 1'b1;
            watchdog_expired_n    <= 1'b1;
            watchdog_expired_n_oe <= 1'b0;
            power_fail_warn_n     <= 1'b0;
            power_fail_warn_n_oe  <= 1'b0;
        end else begin
            if (RESET_OPEN) begin
                reset_out_low    <= 1'b0;
                reset_out_low_oe <= reset_active;
            end else begin
                reset_out_low    <= RESET_HIGH ? reset_active
                                               : !reset_active;
                reset_out_low_oe <= 1'b1;
            end
            if (!HAS_WDOG_OUT) begin
                watchdog_expired_n    <= 1'b1;
                watchdog_expired_n_oe <= 1'b0;
            end else if (WDOG_OPEN) begin
                watchdog_expired_n    <= 1'b0;
                watchdog_expired_n_oe <= wdog_flag
                                         || (reset_active && uv_cause);
            end else begin
                watchdog_expired_n    <= !(wdog_flag
                                         || (reset_active && uv_cause));
                watchdog_expired_n_oe <= 1'b1;
            end
            power_fail_warn_n    <= 1'b0;
            power_fail_warn_n_oe <= HAS_PFAIL && power_fail_sense;
        end
    end

    // Interrupt events: reset entry, watchdog overflow, power-fail and
    // under-voltage rising edges
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pfail_q    <= 1'b0;
            rail_any_q <= 1'b0;
        end else begin
            pfail_q    <= HAS_PFAIL && power_fail_sense;
            rail_any_q <= |rail_low;
        end
    end

    always_comb begin
        irq_event                = '0;
        irq_event[IRQ_RESET_BIT] = (state == MSS_RUN) && hold_cause;
        irq_event[IRQ_WDOG_BIT]  = wdog_over;
        irq_event[IRQ_PFAIL_BIT] = HAS_PFAIL && power_fail_sense && !pfail_q;
        irq_event[IRQ_UV_BIT]    = (|rail_low) && !rail_any_q;
    end

    assign irq_clear = (reg_write && reg_addr == OFS_IRQ_STATUS)
                       ? reg_wdata[IRQ_W-1:0] : '0;

    // Set wins over a write-one clear landing in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= IRQ_MASK_RESET;
            ctrl     <= CTRL_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                OFS_IRQ_MASK: irq_mask <= reg_wdata[IRQ_W-1:0];
                OFS_CTRL:     ctrl     <= {31'h0, reg_wdata[CTRL_FORCE_BIT]};
                default:      ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // Read data stand for the one cycle after the strobe, zero otherwise
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                OFS_CTRL:       reg_rdata <= ctrl;
                OFS_IRQ_STATUS: reg_rdata <= {28'h0, irq_status};
                OFS_IRQ_MASK:   reg_rdata <= {28'h0, irq_mask};
                OFS_STATE: begin
                    reg_rdata                           <= '0;
                    reg_rdata[ST_RAILS_LSB +: RAILS]    <= rail_low;
                    reg_rdata[ST_RESET_BIT]             <= reset_active;
                    reg_rdata[ST_WDOG_BIT]              <= wdog_flag;
                    reg_rdata[ST_PFAIL_BIT]             <= HAS_PFAIL
                                                           && power_fail_sense;
                    reg_rdata[ST_MANUAL_BIT]            <= manual_on;
                    reg_rdata[ST_FSM_LSB +: 3]          <= state;
                end
                default:        reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule // mss_supervisor
`default_nettype wire

// ==== bench/mss_cpu_model.sv ====
/*
 * Processor model that receives the reset pin and toggles the kick pin.
 * Assumes the reset pin is already resolved to its wire level.
 */
`timescale 1ns/1ps
`default_nettype none
module mss_cpu_model #(
    parameter int unsigned PERIOD = 300
) (
    input  wire logic clock,
    input  wire logic reset_pin,
    input  wire logic kick_en,
    output logic      kick
);
    int unsigned cnt = 0;
    initial kick = 1'b0;
    // Code runs only out of reset; a stalled program stops kicking
    always @(posedge clock) begin
        if (reset_pin == 1'b0 || !kick_en) begin
            cnt <= 0;
        end else if (cnt == PERIOD - 1) begin
            cnt <= 0;
            kick <= ~kick;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // mss_cpu_model
`default_nettype wire

// ==== bench/mss_props.sv ====
/*
 * Port checker of the supervisor, bound to every instance.
 * Assumes open-drain reset and watchdog pins and a dedicated watchdog pin.
 */
`timescale 1ns/1ps
`default_nettype none
module mss_props
    import mss_pkg::*;
#(
    parameter int unsigned RESET_TICKS = 5,
    parameter int unsigned WDOG_TICKS  = 8
) (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        primary_supply_monitor,
    input wire logic        secondary_supply_monitor,
    input wire logic        adjustable_monitor_a,
    input wire logic        adjustable_monitor_b,
    input wire logic        manual_reset_n,
    input wire logic        watchdog_kick_in,
    input wire logic        power_fail_sense,
    input wire logic        reset_out_low,
    input wire logic        reset_out_low_oe,
    input wire logic        watchdog_expired_n,
    input wire logic        watchdog_expired_n_oe,
    input wire logic        power_fail_warn_n,
    input wire logic        power_fail_warn_n_oe,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        irq
);
    localparam int unsigned LOW_HIT = GLITCH_CYCLES + 3;
    localparam int unsigned LIM =
        GLITCH_CYCLES + (RESET_TICKS + 1) * TICK_CYCLES + 8;
    localparam int unsigned WD_HIT = (WDOG_TICKS + 1) * TICK_CYCLES + 8;
    localparam int unsigned WD_LOW = (WDOG_TICKS - 1) * TICK_CYCLES;
    wire logic any_low = primary_supply_monitor | secondary_supply_monitor |
        adjustable_monitor_a | adjustable_monitor_b;
    int unsigned low_run;
    int unsigned clean;
    int unsigned quiet;
    logic        force_on;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) low_run <= 0;
        else low_run <= any_low ? low_run + 1 : 0;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) force_on <= 1'b0;
        else if (reg_write && reg_addr == OFS_CTRL)
            force_on <= reg_wdata[CTRL_FORCE_BIT];
    end
    // Cycles with no reset cause at all; filter delay included in LIM
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) clean <= 0;
        else if (any_low || !manual_reset_n || force_on) clean <= 0;
        else clean <= clean + 1;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) quiet <= 0;
        else if (reset_out_low_oe || $changed(watchdog_kick_in)) quiet <= 0;
        else quiet <= quiet + 1;
    end
    rail_reset_a: assert property (low_run == LOW_HIT |->
        reset_out_low_oe && !reset_out_low) else $error("rail low, no reset");
    uv_wdog_a: assert property (low_run == LOW_HIT |->
        watchdog_expired_n_oe && !watchdog_expired_n) else $error("uv no wdo");
    release_lim_a: assert property (clean == LIM |->
        !reset_out_low_oe) else $error("reset held too long");
    hold_min_a: assert property ($fell(reset_out_low_oe) |->
        clean >= (RESET_TICKS - 1) * TICK_CYCLES) else $error("short hold");
    manual_hold_a: assert property (!manual_reset_n [*3] |->
        reset_out_low_oe && !reset_out_low) else $error("manual ignored");
    // Open-drain pin: its level is always low, only the enable tells
    wdog_fire_a: assert property (quiet == WD_HIT |->
        watchdog_expired_n_oe && !watchdog_expired_n)
        else $error("watchdog did not fire");
    wdog_early_a: assert property (quiet > 4 && quiet < WD_LOW &&
        low_run == 0 |-> !watchdog_expired_n_oe)
        else $error("early watchdog");
    kick_clear_a: assert property (!reset_out_low_oe && low_run == 0 &&
        $changed(watchdog_kick_in) |-> ##[1:4] !watchdog_expired_n_oe)
        else $error("kick did not clear");
    pfail_pin_a: assert property ((power_fail_warn_n_oe &&
        !power_fail_warn_n) == $past(power_fail_sense))
        else $error("power-fail pin wrong");
    rdata_idle_a: assert property (!$past(reg_read) |->
        reg_rdata == 32'h0) else $error("read data outside slot");
    cover property ($rose(reset_out_low_oe));
    cover property ($fell(watchdog_expired_n));
    cover property ($rose(irq));
endmodule // mss_props
bind mss_supervisor mss_props #(.RESET_TICKS(RESET_TICKS),
    .WDOG_TICKS(WDOG_TICKS)) mss_props_inst (.*);
`default_nettype wire

// ==== bench/testbench.sv ====
/*
 * Self-checking bench of the supervisor with a processor model.
 * Assumes short reset and watchdog counts and a 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module testbench;
    import mss_pkg::*;
    logic        clock;
    logic        rst_n = 1'b0;
    logic [3:0]  rail = 4'h0;
    logic        manual_reset_n = 1'b1;
    logic        kick_open = 1'b0;
    logic        pf_sense = 1'b0;
    logic        kick_en = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        smp = 1'b0;
    logic        rd_d = 1'b0;
    logic [31:0] reg_rdata;
    logic        irq, kick, rst_lvl, rst_oe, wdo_lvl, wdo_oe, pf_lvl, pf_oe;
    logic [63:0] rq[$];
    logic [3:0]  pq[$];
    int          errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    // Open-drain pins sit on pull-ups
    wire logic rst_pin = rst_oe ? rst_lvl : 1'b1;
    wire logic wdo_pin = wdo_oe ? wdo_lvl : 1'b1;
    wire logic pf_pin = pf_oe ? pf_lvl : 1'b1;
    mss_supervisor #(.RESET_TICKS(5), .WDOG_TICKS(8), .HAS_WDOG_OUT(1'b1),
        .HAS_PFAIL(1'b1)) mss_supervisor_inst (
        .clock(clock), .rst_n(rst_n), .primary_supply_monitor(rail[0]),
        .secondary_supply_monitor(rail[1]), .adjustable_monitor_a(rail[2]),
        .adjustable_monitor_b(rail[3]), .manual_reset_n(manual_reset_n),
        .watchdog_kick_in(kick), .watchdog_kick_open(kick_open),
        .power_fail_sense(pf_sense), .reset_out_low(rst_lvl),
        .reset_out_low_oe(rst_oe), .watchdog_expired_n(wdo_lvl),
        .watchdog_expired_n_oe(wdo_oe), .power_fail_warn_n(pf_lvl),
        .power_fail_warn_n_oe(pf_oe), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .irq(irq));
    mss_cpu_model mss_cpu_model_inst (.clock(clock), .reset_pin(rst_pin),
        .kick_en(kick_en), .kick(kick));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        // Let an edge pass so a following call never rewrites the strobe
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        reg_addr <= a;
        reg_read <= 1'b1;
        rq.push_back({m, e});
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
    endtask
    // Expected {reset pin, watchdog pin, power-fail pin, irq}
    task automatic pins(input logic [3:0] e);
        pq.push_back(e);
        smp <= 1'b1;
        @(posedge clock);
        smp <= 1'b0;
    endtask
    task automatic results();
        $display("errors=%0d check_count=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        logic [63:0] x;
        logic [3:0]  p;
        rd_d <= reg_read;
        if (rd_d) begin
            x = rq.pop_front();
            `CHK(reg_rdata & x[63:32], x[31:0])
        end
        if (smp) begin
            p = pq.pop_front();
            `CHK({rst_pin, wdo_pin, pf_pin, irq}, p)
        end
    end
    // Ceiling well above the roughly 30000 cycles the run needs
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            results();
        end
    end
    initial begin
        int n;
        void'($urandom(32'h6e88));
        step(6);
        rst_n <= 1'b1;
        step(900);
        pins(4'b0110);
        rd(OFS_IRQ_MASK, 32'h0, 32'hf);
        rd(8'h10, 32'h0, 32'hffffffff);
        step(350);
        pins(4'b1110);
        rd(OFS_STATE, 32'h400, 32'h7ff);
        $display("power-up test done");
        for (int i = 0; i < 4; i++) begin
            n = 500 + $urandom % 1400;
            rail[i] <= 1'b1;
            step(n);
            rail[i] <= 1'b0;
            step(10);
            pins(4'b1110);
            rail[i] <= 1'b1;
            step(2010);
            pins(4'b0010);
            rd(OFS_STATE, 32'h110 | (32'h1 << i), 32'h7ff);
            rail[i] <= 1'b0;
            step(3250);
            pins(4'b1110);
        end
        $display("rail test done");
        manual_reset_n <= 1'b0;
        step(5);
        pins(4'b0110);
        rd(OFS_STATE, 32'h190, 32'h7ff);
        manual_reset_n <= 1'b1;
        step(1250);
        pins(4'b1110);
        wr(OFS_CTRL, 32'h1);
        step(5);
        pins(4'b0110);
        rd(OFS_CTRL, 32'h1, 32'h1);
        wr(OFS_CTRL, 32'h0);
        step(1250);
        pins(4'b1110);
        $display("manual test done");
        kick_en <= 1'b0;
        kick_open <= 1'b1;
        step(1000);
        pins(4'b1110);
        step(900);
        pins(4'b1010);
        rd(OFS_STATE, 32'h420, 32'h7ff);
        kick_open <= 1'b0;
        kick_en <= 1'b1;
        step(320);
        pins(4'b1110);
        $display("watchdog test done");
        wr(OFS_IRQ_STATUS, 32'hf);
        wr(OFS_IRQ_MASK, 32'h4);
        rd(OFS_IRQ_STATUS, 32'h0, 32'hf);
        pf_sense <= 1'b1;
        step(4);
        pins(4'b1101);
        rd(OFS_IRQ_STATUS, 32'h4, 32'hf);
        wr(OFS_IRQ_STATUS, 32'h4);
        step(3);
        pins(4'b1100);
        pf_sense <= 1'b0;
        step(3);
        pins(4'b1110);
        $display("power-fail test done");
        results();
    end
endmodule // testbench
`default_nettype wire
